/* File: teu_far_model.sv */
module teu_far_model
  import teu_pkg::*;
#(
  parameter int NUM_THREADS = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [NUM_THREADS-1:0] run,
  input wire logic [NUM_THREADS-1:0] app_issue_hold,
  input wire teu_pkg::teu_ip_load_t ip_load,
  output logic [NUM_THREADS-1:0][31:0] cur_ip
);
  // ----------------------------------------------------------------
  // Issue pipeline: one IP per thread, advancing when allowed
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        cur_ip[t] <= 32'(32'h1000 * (t + 1));
      end
    end else begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        if (ip_load.valid && ip_load.thread == TEU_TID_W'(t)) begin
          cur_ip[t] <= ip_load.addr;
        end else if (run[t] && !app_issue_hold[t]) begin
          cur_ip[t] <= cur_ip[t] + 32'h10;
        end
      end
    end
  end
endmodule

/* File: teu_pkg.sv */
package teu_pkg;

  // ----------------------------------------------------------------
  // Exception types
  // ----------------------------------------------------------------
  localparam int TEU_NUM_TYPES = 5;
  localparam int TEU_EXC_STACK = 0;
  localparam int TEU_EXC_SOFT = 1;
  localparam int TEU_EXC_BRK = 2;
  localparam int TEU_EXC_ILLEGAL = 3;
  localparam int TEU_EXC_HALT = 4;
  typedef logic [TEU_NUM_TYPES-1:0] teu_exc_vec_t;
  localparam teu_exc_vec_t TEU_HALT_MASK = 5'h10;
  localparam teu_exc_vec_t TEU_NO_EXC = 5'h00;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TEU_TID_W = 4;
  localparam int TEU_ADDR_W = 8;
  localparam int TEU_ENTRY_LSB = 4;
  localparam int TEU_ENTRY_W = 32 - TEU_ENTRY_LSB;
  localparam logic [TEU_ENTRY_LSB-1:0] TEU_ENTRY_PAD = 4'h0;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [TEU_ADDR_W-1:0] TEU_OFF_ENTRY = 8'h00;
  localparam logic [3:0] TEU_REG_CTRL = 4'h0;
  localparam logic [3:0] TEU_REG_ENSTAT = 4'h4;
  localparam logic [3:0] TEU_REG_RET = 4'h8;
  localparam int TEU_MASTER_BIT = 0;
  localparam int TEU_EN_LSB = 0;
  localparam int TEU_STAT_LSB = 8;
  localparam logic [31:0] TEU_READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Thread state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TEU_ST_APP = 2'b00,
    TEU_ST_ENTER = 2'b01,
    TEU_ST_ROUTINE = 2'b10,
    TEU_ST_LEAVE = 2'b11
  } teu_state_t;

  typedef struct packed {
    teu_state_t st;
    teu_exc_vec_t en;
    teu_exc_vec_t stat;
    logic [31:0] ret;
  } teu_thread_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [TEU_ADDR_W-1:0] address;
    logic [31:0] writedata;
  } teu_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } teu_avs_rsp_t;

  typedef struct packed {
    logic valid;
    logic [TEU_TID_W-1:0] thread;
    teu_exc_vec_t mask;
  } teu_dispatch_t;

  typedef struct packed {
    logic valid;
    logic [TEU_TID_W-1:0] thread;
    teu_exc_vec_t types;
  } teu_event_t;

  typedef struct packed {
    logic valid;
    logic [TEU_ENTRY_W-1:0] addr;
  } teu_entry_load_t;

  typedef struct packed {
    logic valid;
    logic [TEU_TID_W-1:0] thread;
    logic entry;
    logic [31:0] addr;
  } teu_ip_load_t;

endpackage

/* File: teu_top.sv */
// Behaviour
// - Five exception types; four synchronous from issue, halt asynchronous from a pin.
// - A thread latches only exception types whose enable bit is set.
// - New-thread dispatch loads the delivered mask into that thread's enables.
// - Enables are read/write by software anytime; effect on later recognition.
// - One 32-bit entry pointer per context, loaded at each context switch.
// - Every hardware thread has its own three exception control registers.
// - Hardware and software touch exception bits at exclusive times; no atomics.
// - After an exception is raised, no application instruction issues until return.
// - On entry save thread IP as return pointer, then load entry pointer.
// - Routine keeps the thread's priority, register space and thread state.
// - Register-in-flight dependencies of the thread stay enforced in the routine.
// - Exceptions inside the routine are latched but cause no nested entry.
// - One pending exception per type; repeats are lost until status cleared.
// - Accumulators are not saved or restored by hardware.
// - Channel masks keep their application values on routine entry.
// - Flags, mask stacks and other registers are not preserved by hardware.
// - Status still set at routine exit forces immediate re-entry.
// - Clearing master bit restores return pointer to IP when nothing pending.
// - Return pointer keeps its captured value unless software writes it.
// - Entry pointer is 16-byte aligned; only upper 28 bits are delivered.
module teu_top #(
  parameter int NUM_THREADS = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire teu_pkg::teu_avs_req_t avs_req,
  output teu_pkg::teu_avs_rsp_t avs_rsp,
  input wire logic halt_pin,
  input wire teu_pkg::teu_dispatch_t dispatch,
  input wire teu_pkg::teu_entry_load_t entry_load,
  input wire teu_pkg::teu_event_t exc_event,
  input wire logic [NUM_THREADS-1:0][31:0] cur_ip,
  output teu_pkg::teu_ip_load_t ip_load,
  output logic [NUM_THREADS-1:0] app_issue_hold
);
  import teu_pkg::*;

  typedef struct packed {
    teu_thread_t [NUM_THREADS-1:0] th;
    logic [TEU_ENTRY_W-1:0] entry;
    logic halt_s1;
    logic halt_s2;
    logic halt_d;
    teu_avs_rsp_t rsp;
    teu_ip_load_t ipl;
    logic [NUM_THREADS-1:0] hold;
  } teu_regs_t;

  teu_regs_t r;
  teu_regs_t next_r;

  logic halt_rise;
  logic acc_first;
  logic wr_take;
  logic grant_found;
  logic [TEU_TID_W-1:0] grant_tid;
  logic [NUM_THREADS-1:0] wr_ctrl;
  logic [NUM_THREADS-1:0] wr_es;
  logic [NUM_THREADS-1:0] wr_ret;
  logic [NUM_THREADS-1:0] master_clear;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    teu_exc_vec_t ev;
    teu_exc_vec_t latch;
    logic [31:0] rd;
    logic hit;
    next_r = r;
    rd = TEU_READ_ZERO;
    ev = TEU_NO_EXC;
    latch = TEU_NO_EXC;
    hit = 1'b0;
    grant_found = 1'b0;
    grant_tid = '0;
    wr_ctrl = '0;
    wr_es = '0;
    wr_ret = '0;
    master_clear = '0;

    // Halt pin crosses in through two flops, edge taken after them
    next_r.halt_s1 = halt_pin;
    next_r.halt_s2 = r.halt_s1;
    next_r.halt_d = r.halt_s2;
    halt_rise = r.halt_s2 & ~r.halt_d;

    // Bus: one wait cycle, then waitrequest low for exactly one cycle
    acc_first = (avs_req.read | avs_req.write) & r.rsp.waitrequest;
    wr_take = avs_req.write & ~r.rsp.waitrequest;
    next_r.rsp.waitrequest = ~acc_first;

    // Per-context entry pointer from the context loader
    if (entry_load.valid) begin
      next_r.entry = entry_load.addr;
    end

    // Lowest numbered thread needing an IP redirect wins this cycle
    for (int t = NUM_THREADS - 1; t >= 0; t--) begin
      if (r.th[t].st == TEU_ST_ENTER || r.th[t].st == TEU_ST_LEAVE) begin
        grant_found = 1'b1;
        grant_tid = TEU_TID_W'(t);
      end
    end

    if (avs_req.address == TEU_OFF_ENTRY) begin
      rd = {r.entry, TEU_ENTRY_PAD};
    end

    for (int t = 0; t < NUM_THREADS; t++) begin
      hit = (avs_req.address[7:4] == 4'(t + 1));
      wr_ctrl[t] = wr_take & hit & (avs_req.address[3:0] == TEU_REG_CTRL);
      wr_es[t] = wr_take & hit & (avs_req.address[3:0] == TEU_REG_ENSTAT);
      wr_ret[t] = wr_take & hit & (avs_req.address[3:0] == TEU_REG_RET);
      master_clear[t] = wr_ctrl[t] & ~avs_req.writedata[TEU_MASTER_BIT];

      if (hit && avs_req.address[3:0] == TEU_REG_CTRL) begin
        rd = 32'(r.th[t].st != TEU_ST_APP);
      end
      if (hit && avs_req.address[3:0] == TEU_REG_ENSTAT) begin
        rd = (32'(r.th[t].stat) << TEU_STAT_LSB) | 32'(r.th[t].en);
      end
      if (hit && avs_req.address[3:0] == TEU_REG_RET) begin
        rd = r.th[t].ret;
      end

      // Gather this thread's events
      ev = TEU_NO_EXC;
      if (exc_event.valid && exc_event.thread == TEU_TID_W'(t)) begin
        ev = exc_event.types & ~TEU_HALT_MASK;
      end
      if (halt_rise) begin
        ev = ev | TEU_HALT_MASK;
      end

      // Software access to enables and status
      if (wr_es[t]) begin
        next_r.th[t].en = avs_req.writedata[TEU_EN_LSB +: TEU_NUM_TYPES];
        next_r.th[t].stat = r.th[t].stat & ~avs_req.writedata[TEU_STAT_LSB +: TEU_NUM_TYPES];
      end
      latch = ev & r.th[t].en;
      // Event beats a clear in the same cycle; repeats merge into one bit
      next_r.th[t].stat = next_r.th[t].stat | latch;

      if (wr_ret[t]) begin
        next_r.th[t].ret = avs_req.writedata;
      end

      case (r.th[t].st)
        TEU_ST_APP: begin
          // Any latched status gives a single entry for all types
          if (|next_r.th[t].stat) begin
            next_r.th[t].st = TEU_ST_ENTER;
            next_r.th[t].ret = cur_ip[t];
          end
        end
        TEU_ST_ENTER: begin
          if (grant_found && grant_tid == TEU_TID_W'(t)) begin
            next_r.th[t].st = TEU_ST_ROUTINE;
          end
        end
        TEU_ST_ROUTINE: begin
          // No nested entry here; exit decided by the master bit, or by a dispatch to this thread
          if (master_clear[t]) begin
            if (|next_r.th[t].stat) begin
              next_r.th[t].st = TEU_ST_ENTER;
            end else begin
              next_r.th[t].st = TEU_ST_LEAVE;
            end
          end
        end
        TEU_ST_LEAVE: begin
          if (grant_found && grant_tid == TEU_TID_W'(t)) begin
            next_r.th[t].st = TEU_ST_APP;
          end
        end
        default: begin
          next_r.th[t].st = TEU_ST_APP;
        end
      endcase

      // Dispatch starts the thread afresh with the kernel's mask
      if (dispatch.valid && dispatch.thread == TEU_TID_W'(t)) begin
        next_r.th[t].en = dispatch.mask;
        next_r.th[t].stat = TEU_NO_EXC;
        next_r.th[t].st = TEU_ST_APP;
      end

      next_r.hold[t] = (next_r.th[t].st != TEU_ST_APP);
    end

    if (acc_first) begin
      next_r.rsp.readdata = rd;
    end

    // Only the IP is redirected, on the same thread slot and priority.
    // Scoreboard, accumulators, channel masks, flags and mask stacks are untouched.
    next_r.ipl.valid = grant_found;
    next_r.ipl.thread = grant_tid;
    next_r.ipl.entry = (r.th[grant_tid].st == TEU_ST_ENTER);
    if (r.th[grant_tid].st == TEU_ST_ENTER) begin
      next_r.ipl.addr = {r.entry, TEU_ENTRY_PAD};
    end else begin
      next_r.ipl.addr = r.th[grant_tid].ret;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.rsp.waitrequest <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_rsp = r.rsp;
  assign ip_load = r.ipl;
  assign app_issue_hold = r.hold;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_hold_on_raise;
    (r.th[0].st == TEU_ST_APP && exc_event.valid && exc_event.thread == '0 &&
     |(exc_event.types & r.th[0].en & ~TEU_HALT_MASK) && !dispatch.valid) |=> app_issue_hold[0];
  endproperty
  a_hold_on_raise: assert property (p_hold_on_raise) else $error("issue not held after exception");

  property p_entry_addr;
    (ip_load.valid && ip_load.entry) |-> (ip_load.addr == {$past(r.entry), TEU_ENTRY_PAD});
  endproperty
  a_entry_addr: assert property (p_entry_addr) else $error("entry redirect not to entry pointer");

  // Thread 0 always wins the redirect slot, so its return pulse follows at once
  property p_return_addr;
    r.th[0].st == TEU_ST_LEAVE |=>
      (ip_load.valid && !ip_load.entry && ip_load.thread == '0 && ip_load.addr == $past(r.th[0].ret));
  endproperty
  a_return_addr: assert property (p_return_addr) else $error("return redirect address wrong");

  property p_no_nesting;
    (r.th[0].st == TEU_ST_ROUTINE && !master_clear[0] && !dispatch.valid) |=> r.th[0].st == TEU_ST_ROUTINE;
  endproperty
  a_no_nesting: assert property (p_no_nesting) else $error("routine left without master clear");

  property p_masked_ignored;
    (exc_event.valid && exc_event.thread == '0 && !halt_rise && !wr_es[0] && !dispatch.valid &&
     ((exc_event.types & r.th[0].en) == TEU_NO_EXC)) |=> $stable(r.th[0].stat);
  endproperty
  a_masked_ignored: assert property (p_masked_ignored) else $error("disabled exception latched");

  property p_dispatch_mask;
    (dispatch.valid && dispatch.thread == '0) |=> (r.th[0].en == $past(dispatch.mask) && r.th[0].stat == TEU_NO_EXC);
  endproperty
  a_dispatch_mask: assert property (p_dispatch_mask) else $error("dispatch mask not loaded");

  property p_reenter;
    (r.th[0].st == TEU_ST_ROUTINE && master_clear[0] && |r.th[0].stat && !dispatch.valid &&
     !wr_es[0]) |=> r.th[0].st == TEU_ST_ENTER ##[1:4] (ip_load.valid && ip_load.entry);
  endproperty
  a_reenter: assert property (p_reenter) else $error("no re-entry with status pending");

  property p_ret_kept;
    (r.th[0].st == TEU_ST_ROUTINE && !wr_ret[0] && !dispatch.valid) |=> r.th[0].ret == $past(r.th[0].ret);
  endproperty
  a_ret_kept: assert property (p_ret_kept) else $error("return pointer changed in routine");

  property p_entry_load;
    entry_load.valid |=> r.entry == $past(entry_load.addr);
  endproperty
  a_entry_load: assert property (p_entry_load) else $error("entry pointer not loaded");

  property p_single_entry;
    (ip_load.valid && ip_load.entry && ip_load.thread == '0) |=> !(ip_load.valid && ip_load.entry &&
      ip_load.thread == '0);
  endproperty
  a_single_entry: assert property (p_single_entry) else $error("double entry for one raise");

  c_entry: cover property (ip_load.valid && ip_load.entry);
  c_return: cover property (ip_load.valid && !ip_load.entry);
  c_reenter: cover property (r.th[0].st == TEU_ST_ROUTINE ##1 r.th[0].st == TEU_ST_ENTER);
  c_halt: cover property (halt_rise && |(r.th[0].en & TEU_HALT_MASK));

endmodule

/* File: thread_exception_unit_bench.sv */
module thread_exception_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import teu_pkg::*;
  localparam int NT = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  teu_avs_req_t avs_req = '0;
  teu_avs_rsp_t avs_rsp;
  logic halt_pin = 1'b0;
  teu_dispatch_t dispatch = '0;
  teu_entry_load_t entry_load = '0;
  teu_event_t exc_event = '0;
  logic [NT-1:0][31:0] cur_ip;
  teu_ip_load_t ip_load;
  teu_ip_load_t e_seen;
  logic [NT-1:0] app_issue_hold;
  logic [NT-1:0] run = '0;
  logic [31:0] seed = 32'h7E64E65D;
  logic [31:0] entry = '0;
  logic [31:0] saved = '0;
  int miscompares = 0;
  int checks = 0;
  teu_ip_load_t eq[$];
  logic [31:0] rq[$];

  always #25 clk = ~clk;

  teu_top #(.NUM_THREADS(NT)) u_dut (.clk(clk), .rstn(rstn), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .halt_pin(halt_pin), .dispatch(dispatch), .entry_load(entry_load), .exc_event(exc_event),
    .cur_ip(cur_ip), .ip_load(ip_load), .app_issue_hold(app_issue_hold));
  teu_far_model #(.NUM_THREADS(NT)) u_far (.clk(clk), .rstn(rstn), .run(run),
    .app_issue_hold(app_issue_hold), .ip_load(ip_load), .cur_ip(cur_ip));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic teu_ip_load_t mk(input int t, input logic ent, input logic [31:0] a);
    return '{valid: 1'b1, thread: TEU_TID_W'(t), entry: ent, addr: a};
  endfunction

  function automatic logic [7:0] base(input int t);
    return 8'(16 * (t + 1));
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_req <= '{read: ~w, write: w, address: a, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0);
    chk("waitrequest", 64'(avs_rsp.waitrequest), 64'(0));
    chk("wait edges", 64'(n), 64'(2));
    avs_req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic disp(input int t, input teu_exc_vec_t m);
    dispatch <= '{valid: 1'b1, thread: TEU_TID_W'(t), mask: m};
    @(posedge clk);
    dispatch <= '0;
    @(posedge clk);
  endtask

  task automatic ev(input int t, input teu_exc_vec_t ty, input logic take);
    exc_event <= '{valid: 1'b1, thread: TEU_TID_W'(t), types: ty};
    @(posedge clk);
    if (take) begin
      saved = cur_ip[t];
      eq.push_back(mk(t, 1'b1, entry));
    end
    exc_event <= '0;
    @(posedge clk);
  endtask

  task automatic leave(input int t, input logic re, input logic [31:0] ra);
    eq.push_back(mk(t, re, re ? entry : ra));
    wr(base(t), 32'h0);
  endtask

  task automatic drain(input string name);
    repeat (6) @(posedge clk);
    chk("pending redirects", 64'(eq.size()), 64'(0));
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Monitor: compares every redirect and read against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    seed <= xorshift(seed);
    run <= seed[NT-1:0] & 4'hB;
    if (rstn && ip_load.valid === 1'b1) begin
      if (eq.size() == 0) begin
        chk("unexpected redirect", 64'(1), 64'(0));
      end else begin
        e_seen = eq.pop_front();
        chk("ip_load", 64'(ip_load), 64'(e_seen));
        chk("hold", 64'(app_issue_hold[ip_load.thread]), 64'(e_seen.entry));
      end
    end
    if (rstn && avs_req.read === 1'b1 && avs_rsp.waitrequest === 1'b0) begin
      chk("readdata", 64'(avs_rsp.readdata), 64'(rq.pop_front()));
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(base(0) + 8'h4, 32'h0);
    entry = {seed[31:4], 4'h0};
    entry_load <= '{valid: 1'b1, addr: seed[31:4]};
    @(posedge clk);
    entry_load <= '0;
    @(posedge clk);
    rd(8'h00, entry);
    rd(8'hF0, 32'h0);
    disp(0, 5'h0F);
    disp(1, 5'h00);
    disp(2, 5'h10);
    disp(3, 5'h00);
    rd(base(0) + 8'h4, 32'h0F);
    rd(base(1) + 8'h4, 32'h0);
    ev(1, 5'h02, 1'b0);
    ev(0, 5'h06, 1'b1);
    drain("entry");
    rd(base(0) + 8'h8, saved);
    rd(base(0), 32'h1);
    rd(base(0) + 8'h4, 32'h60F);
    ev(0, 5'h01, 1'b0);
    drain("nested");
    rd(base(0) + 8'h4, 32'h70F);
    wr(base(0) + 8'h4, 32'h60F);
    leave(0, 1'b1, 32'h0);
    drain("reentry");
    rd(base(0) + 8'h8, saved);
    wr(base(0) + 8'h4, 32'h10F);
    wr(base(0) + 8'h8, 32'h4440);
    leave(0, 1'b0, 32'h4440);
    drain("return");
    rd(base(0), 32'h0);
    wr(base(0) + 8'h4, 32'h0);
    ev(0, 5'h0F, 1'b0);
    drain("disable");
    rd(base(0) + 8'h4, 32'h0);
    saved = cur_ip[2];
    eq.push_back(mk(2, 1'b1, entry));
    halt_pin <= 1'b1;
    drain("halt");
    halt_pin <= 1'b0;
    rd(base(2) + 8'h8, saved);
    rd(base(2) + 8'h4, 32'h1010);
    wr(base(2) + 8'h4, 32'h1010);
    leave(2, 1'b0, saved);
    drain("halt return");
    end_of_test();
  end
endmodule
